// >>> hw/tcs_channel.sv
// tcs_channel: one 16-bit channel counter with compare match and clear.
// assumes: count pulses come from the top on the same clock, up and down
// never together; registers C and D exist only when HAS_CD is set.
`timescale 1ns/1ps
module tcs_channel
    import tcs_pkg::*;
#(
    parameter bit HAS_CD = 1'b0
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // count and configuration
    input  wire logic        cnt_up,
    input  wire logic        cnt_dn,
    input  wire logic [2:0]  clr_code,
    input  wire logic        sync_en,
    input  wire logic        sync_any,
    input  wire logic        buf_a,
    input  wire logic        buf_b,
    // software counter write
    input  wire logic        cnt_we,
    input  wire logic [15:0] cnt_wdata,
    // general registers
    input  wire logic [15:0] gr_a,
    input  wire logic [15:0] gr_b,
    input  wire logic [15:0] gr_c,
    input  wire logic [15:0] gr_d,
    // state and events
    output logic      [15:0] counter,
    output logic             src_clear,
    output logic             clr_evt,
    output logic             ovf_evt
);

    logic match_a;
    logic match_b;
    logic match_c;
    logic match_d;
    logic sync_clear;

    ////////////////////////////////////////////////////////////////////////
    // compare match; a buffer register never matches
    assign match_a = (counter == gr_a);
    assign match_b = (counter == gr_b);
    assign match_c = HAS_CD && !buf_a && (counter == gr_c);
    assign match_d = HAS_CD && !buf_b && (counter == gr_d);

    // clear source decode; codes 000, 011, 100 and 111 give no source clear
    always_comb begin
        case (clr_code)
            CLR_A:   src_clear = match_a;
            CLR_B:   src_clear = match_b;
            CLR_C:   src_clear = match_c;
            CLR_D:   src_clear = match_d;
            default: src_clear = 1'b0;
        endcase
    end

    // synchronous clear only for channels enrolled in sync operation
    assign sync_clear = (clr_code[1:0] == 2'b11) && sync_en && sync_any;
    assign clr_evt    = src_clear || sync_clear;

    // wrap events feed a neighbour's count input in the same cycle
    assign ovf_evt = !cnt_we && !clr_evt &&
                     ((cnt_up && counter == 16'hffff) ||
                      (cnt_dn && counter == 16'h0000));

    ////////////////////////////////////////////////////////////////////////
    // counter: software write, then clear, then count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            counter <= CNT_RESET;
        end else if (cnt_we) begin
            counter <= cnt_wdata;
        end else if (clr_evt) begin
            counter <= 16'h0000;
        end else if (cnt_up) begin
            counter <= counter + 16'h0001;
        end else if (cnt_dn) begin
            counter <= counter - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    clear_on_a_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clr_code == CLR_A && match_a && !cnt_we) |=> counter == 16'h0000)
        else $error("counter not cleared on match A");
    buffer_no_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (buf_a && clr_code == CLR_C) |-> !src_clear)
        else $error("buffer register C cleared the counter");
    sync_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clr_code[1:0] == 2'b11 && sync_any && !cnt_we) |=>
        (counter == 16'h0000) == $past(sync_en))
        else $error("sync clear does not follow enrolment");
    clear_cd_a: assert property (@(posedge clk) disable iff (!rst_n)
        (HAS_CD && clr_code == CLR_D && !buf_b && counter == gr_d &&
         !cnt_we) |=> counter == 16'h0000)
        else $error("counter not cleared on match D");

endmodule

// >>> hw/tcs_timer.sv
// tcs_timer: six-channel timer, clear source and count clock selection,
// with a classic wishbone register slave.
// assumes: one 40 MHz clock, synchronous active-low reset, clock pins
// asynchronous to it and slower than half its rate.
// Operation
// - channels 1,2,4,5 clear codes: none, match A, match B, sync clear.
// - control bit 7 on channels 1,2,4,5 reads zero and ignores writes.
// - sync clear acts only when the channel's sync enable bit is one.
// - registers C or D used as buffers never match nor clear.
// - prescale codes 000 to 011 count on clock divided by 1,4,16,64.
// - channel 0 codes 100 to 111 count on clock pins A,B,C,D.
// - channel 1 codes: pin A, pin B, clock/256, channel 2 wrap.
// - phase counting on channels 1,2,4,5 overrides the prescale selection.
// - channel 2 codes: pins A,B,C then clock divided by 1024.
// - channel 3 codes: pin A, then clock divided by 1024,256,4096.
// - channel 4 codes: pin A, pin C, clock/1024, channel 5 wrap.
// - channel 5 codes: pin A, pin C, clock/256, pin D; phase overrides.
// - channels 0,3 add clear on C or D; 100 none, 111 sync clear.
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module tcs_timer
    import tcs_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // external clock pins
    input  wire logic        EXT_CLOCK_IN_A,
    input  wire logic        EXT_CLOCK_IN_B,
    input  wire logic        EXT_CLOCK_IN_C,
    input  wire logic        EXT_CLOCK_IN_D,
    // counter wrap events, one-cycle pulses
    output logic      [5:0]  COUNTER_WRAP
);

    logic [7:0]         ctrl     [NCH];
    logic [7:0]         mode     [NCH];
    logic [15:0]        gr       [NCH][4];
    logic [5:0]         sync_sel;
    logic [5:0]         start;
    logic [PRESC_W-1:0] presc;
    logic [NDIV-1:0]    div;
    logic [3:0]         ext_s1;
    logic [3:0]         ext_s2;
    logic [3:0]         ext_s3;
    logic [3:0]         ext_rise;
    logic [15:0]        cnt      [NCH];
    logic [5:0]         src_clear;
    logic [5:0]         clr_evt;
    logic [5:0]         ovf_evt;
    logic [5:0]         cnt_up;
    logic [5:0]         cnt_dn;
    logic [5:0]         cnt_we;
    logic [15:0]        cnt_wdata;
    logic [2:0]         bank;
    logic [2:0]         reg_sel;
    logic               bank_ch;
    int                 chi;
    logic               req;
    logic               wr_fire;
    logic [31:0]        rd_data;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // merge a 16-bit register with the enabled byte lanes of a write
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? wd[15:8] : old[15:8],
                   sel[0] ? wd[7:0]  : old[7:0]};
    endfunction

    // count clock selected by a channel's prescale field
    function automatic logic pick_tick(input int ch,
                                       input logic [2:0] psc,
                                       input logic [NDIV-1:0] dv,
                                       input logic [3:0] ex,
                                       input logic ovf2,
                                       input logic ovf5);
        pick_tick = 1'b0;
        if (!psc[2]) begin
            pick_tick = dv[psc[1:0]];
        end else begin
            case (ch)
                0: pick_tick = ex[psc[1:0]];
                1: case (psc[1:0])
                    2'b00:   pick_tick = ex[0];
                    2'b01:   pick_tick = ex[1];
                    2'b10:   pick_tick = dv[DV_256];
                    default: pick_tick = ovf2;
                endcase
                2: pick_tick = (psc[1:0] == 2'b11) ? dv[DV_1024]
                                                    : ex[psc[1:0]];
                3: case (psc[1:0])
                    2'b00:   pick_tick = ex[0];
                    2'b01:   pick_tick = dv[DV_1024];
                    2'b10:   pick_tick = dv[DV_256];
                    default: pick_tick = dv[DV_4096];
                endcase
                4: case (psc[1:0])
                    2'b00:   pick_tick = ex[0];
                    2'b01:   pick_tick = ex[2];
                    2'b10:   pick_tick = dv[DV_1024];
                    default: pick_tick = ovf5;
                endcase
                default: case (psc[1:0])
                    2'b00:   pick_tick = ex[0];
                    2'b01:   pick_tick = ex[2];
                    2'b10:   pick_tick = dv[DV_256];
                    default: pick_tick = ex[3];
                endcase
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // prescaler: free-running, each tap is a one-cycle enable
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            presc <= '0;
        end else begin
            presc <= presc + PRESC_W'(1);
        end
    end

    always_comb begin
        for (int k = 0; k < NDIV; k++) begin
            div[k] = ~|(presc & PRESC_W'((1 << DIV_BITS[k]) - 1));
        end
    end

    // clock pins: two flops, then a third only for edge detection
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            ext_s1 <= 4'h0;
            ext_s2 <= 4'h0;
            ext_s3 <= 4'h0;
        end else begin
            ext_s1 <= {EXT_CLOCK_IN_D, EXT_CLOCK_IN_C,
                       EXT_CLOCK_IN_B, EXT_CLOCK_IN_A};
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end
    assign ext_rise = ext_s2 & ~ext_s3;

    ////////////////////////////////////////////////////////////////////////
    // count pulses; phase mode counts phase A rises, direction from phase B
    // (channels 1,5 use pins A/B, channels 2,4 use pins C/D)
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            logic ph_rise;
            logic ph_dir;
            ph_rise = (c == 2 || c == 4) ? ext_rise[2] : ext_rise[0];
            ph_dir  = (c == 2 || c == 4) ? ext_s2[3]   : ext_s2[1];
            if (PHASE_MASK[c] && mode[c][MODE_PHASE]) begin
                cnt_up[c] = start[c] && ph_rise && !ph_dir;
                cnt_dn[c] = start[c] && ph_rise && ph_dir;
            end else begin
                cnt_up[c] = start[c] &&
                            pick_tick(c, ctrl[c][PSC_MSB:PSC_LSB], div,
                                      ext_rise, ovf_evt[2], ovf_evt[5]);
                cnt_dn[c] = 1'b0;
            end
        end
    end

    // channels; a sync clear source must not itself select sync clearing
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            tcs_channel #(.HAS_CD(CD_MASK[g])) u_ch (
                .clk       (CLK_SYS),
                .rst_n     (RESET_N),
                .cnt_up    (cnt_up[g]),
                .cnt_dn    (cnt_dn[g]),
                .clr_code  (ctrl[g][CLR_MSB:CLR_LSB]),
                .sync_en   (sync_sel[g]),
                .sync_any  (|(sync_sel & src_clear)),
                .buf_a     (mode[g][MODE_BUFA]),
                .buf_b     (mode[g][MODE_BUFB]),
                .cnt_we    (cnt_we[g]),
                .cnt_wdata (cnt_wdata),
                .gr_a      (gr[g][0]),
                .gr_b      (gr[g][1]),
                .gr_c      (gr[g][2]),
                .gr_d      (gr[g][3]),
                .counter   (cnt[g]),
                .src_clear (src_clear[g]),
                .clr_evt   (clr_evt[g]),
                .ovf_evt   (ovf_evt[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode: ack one cycle after the request, write on ack edge
    assign bank    = WB_ADR_I[7:5];
    assign reg_sel = WB_ADR_I[4:2];
    assign bank_ch = (bank < 3'(NCH));
    assign chi     = bank_ch ? int'(bank) : 0;
    assign req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_fire = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cnt_we[c] = wr_fire && bank_ch && chi == c && reg_sel == REG_CNT
                        && |WB_SEL_I[1:0];
        end
    end
    assign cnt_wdata = merge16(cnt[chi], WB_DAT_I, WB_SEL_I);

    // register writes; absent bits are never stored
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            for (int c = 0; c < NCH; c++) begin
                ctrl[c] <= CTRL_RESET;
                mode[c] <= MODE_RESET;
                for (int k = 0; k < 4; k++) begin
                    gr[c][k] <= GR_RESET;
                end
            end
            sync_sel <= BITS_RESET;
            start    <= BITS_RESET;
        end else if (wr_fire && bank_ch) begin
            if (reg_sel == REG_CTRL && WB_SEL_I[0]) begin
                ctrl[chi] <= WB_DAT_I[7:0];
                if (!CD_MASK[chi]) begin
                    ctrl[chi][CTRL_RSVD] <= 1'b0;
                end
            end else if (reg_sel == REG_MODE && WB_SEL_I[0]) begin
                mode[chi] <= 8'h00;
                mode[chi][MODE_BUFA]  <= CD_MASK[chi] && WB_DAT_I[MODE_BUFA];
                mode[chi][MODE_BUFB]  <= CD_MASK[chi] && WB_DAT_I[MODE_BUFB];
                mode[chi][MODE_PHASE] <= PHASE_MASK[chi] &&
                                         WB_DAT_I[MODE_PHASE];
            end else if (reg_sel >= REG_GRA && reg_sel <= REG_GRD &&
                         (CD_MASK[chi] || reg_sel < REG_GRA + 3'h2)) begin
                gr[chi][2'(reg_sel - REG_GRA)] <=
                    merge16(gr[chi][2'(reg_sel - REG_GRA)], WB_DAT_I,
                            WB_SEL_I);
            end
        end else if (wr_fire && bank == BANK_GLOBAL && WB_SEL_I[0]) begin
            if (reg_sel == REG_SYNC) begin
                sync_sel <= WB_DAT_I[5:0];
            end else if (reg_sel == REG_START) begin
                start <= WB_DAT_I[5:0];
            end
        end
    end

    // read mux; unmapped words read zero and still get an ack
    always_comb begin
        rd_data = 32'h0000_0000;
        if (bank_ch) begin
            case (reg_sel)
                REG_CTRL: rd_data[7:0] = ctrl[chi];
                REG_MODE: rd_data[7:0] = mode[chi];
                REG_CNT:  rd_data[15:0] = cnt[chi];
                default: begin
                    if (reg_sel >= REG_GRA && reg_sel <= REG_GRD &&
                        (CD_MASK[chi] || reg_sel < REG_GRA + 3'h2)) begin
                        rd_data[15:0] = gr[chi][2'(reg_sel - REG_GRA)];
                    end
                end
            endcase
        end else if (bank == BANK_GLOBAL) begin
            if (reg_sel == REG_SYNC) begin
                rd_data[5:0] = sync_sel;
            end else if (reg_sel == REG_START) begin
                rd_data[5:0] = start;
            end
        end
    end

    // bus answer and wrap outputs, all registered
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            WB_ACK_O     <= 1'b0;
            WB_DAT_O     <= 32'h0000_0000;
            COUNTER_WRAP <= 6'h00;
        end else begin
            WB_ACK_O     <= req;
            WB_DAT_O     <= req ? rd_data : 32'h0000_0000;
            COUNTER_WRAP <= ovf_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    ack_single_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for more than one cycle");
    reserved_bit_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        ctrl[1][CTRL_RSVD] == 1'b0 && ctrl[5][CTRL_RSVD] == 1'b0)
        else $error("reserved control bit stored a one");
    div4_spacing_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        div[1] |=> !div[1] [*3] ##1 div[1])
        else $error("divide by 4 tick spacing wrong");
    ext_a_count_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (start[0] && ctrl[0][PSC_MSB:PSC_LSB] == 3'b100 && ext_rise[0] &&
         !clr_evt[0] && !cnt_we[0]) |=> cnt[0] == $past(cnt[0]) + 16'h0001)
        else $error("channel 0 missed a pin A edge");
    neighbour_wrap_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (start[1] && !mode[1][MODE_PHASE] &&
         ctrl[1][PSC_MSB:PSC_LSB] == 3'b111 && ovf_evt[2] &&
         !clr_evt[1] && !cnt_we[1]) |=> cnt[1] == $past(cnt[1]) + 16'h0001)
        else $error("channel 1 missed a channel 2 wrap");
    phase_override_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (mode[1][MODE_PHASE] && !ext_rise[0]) |-> !cnt_up[1] && !cnt_dn[1])
        else $error("phase mode counted off the prescaler");
    div4096_only_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (ctrl[3][PSC_MSB:PSC_LSB] == 3'b111 && cnt_up[3]) |->
        presc == '0)
        else $error("channel 3 counted off the 4096 tap");
    ch2_div1024_a: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (start[2] && !mode[2][MODE_PHASE] &&
         ctrl[2][PSC_MSB:PSC_LSB] == 3'b111) |->
        cnt_up[2] == div[DV_1024])
        else $error("channel 2 not on the 1024 tap");

endmodule

// >>> inc/tcs_pkg.sv
// tcs_pkg: register map, field positions, reset values and divider taps
// for the six-channel timer clear and clock select block.
// assumes: imported by every design file of the block.
package tcs_pkg;

    // channel population
    localparam int         NCH        = 6;
    localparam logic [5:0] CD_MASK    = 6'h09; // channels with regs C and D
    localparam logic [5:0] PHASE_MASK = 6'h36; // channels with phase mode

    // wishbone map: byte address = {bank, reg, 2'b00}
    localparam logic [2:0] BANK_GLOBAL = 3'h6;
    localparam logic [2:0] REG_CTRL    = 3'h0;
    localparam logic [2:0] REG_MODE    = 3'h1;
    localparam logic [2:0] REG_GRA     = 3'h2;
    localparam logic [2:0] REG_GRD     = 3'h5;
    localparam logic [2:0] REG_CNT     = 3'h6;
    localparam logic [2:0] REG_SYNC    = 3'h0;
    localparam logic [2:0] REG_START   = 3'h1;

    // field positions
    localparam int CLR_MSB    = 7;
    localparam int CLR_LSB    = 5;
    localparam int PSC_MSB    = 2;
    localparam int PSC_LSB    = 0;
    localparam int CTRL_RSVD  = 7;
    localparam int MODE_BUFA  = 0;
    localparam int MODE_BUFB  = 1;
    localparam int MODE_PHASE = 2;

    // reset values
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  MODE_RESET = 8'h00;
    localparam logic [15:0] GR_RESET   = 16'hffff;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [5:0]  BITS_RESET = 6'h00;

    // divider taps: tick k fires when the low DIV_BITS[k] bits are zero
    localparam int PRESC_W = 12;
    localparam int NDIV    = 7;
    localparam int DV_256  = 4;
    localparam int DV_1024 = 5;
    localparam int DV_4096 = 6;
    localparam int DIV_BITS [NDIV] = '{0, 2, 4, 6, 8, 10, 12};

    // counter clear sources
    typedef enum logic [2:0] {
        CLR_NONE  = 3'b000,
        CLR_A     = 3'b001,
        CLR_B     = 3'b010,
        CLR_SYNC  = 3'b011,
        CLR_NONE2 = 3'b100,
        CLR_C     = 3'b101,
        CLR_D     = 3'b110,
        CLR_SYNC2 = 3'b111
    } tcs_clear_type;

endpackage

// >>> tb/tb_tcs_timer.sv
// tb_tcs_timer: self-checking bench for timer clear and clock selection.
// assumes: tcs_pkg compiled first; one 40 MHz clock drives the design.
`timescale 1ns/1ps
module tb_tcs_timer;
    import tcs_pkg::*;
    typedef struct {int ch; int psc; int exp;} tcs_row_type;
    logic        clk, rst_n, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q, r1;
    logic [3:0]  ext;
    logic [5:0]  wrap;
    int          err_count, checked, nw;
    // ordinary cases: channel, prescale code, counts in 4096 cycles
    tcs_row_type rows [12] = '{'{0,0,4096}, '{1,1,1024}, '{2,2,256},
        '{4,3,64}, '{1,6,16}, '{2,7,4}, '{3,5,4}, '{3,6,16}, '{3,7,1},
        '{4,6,4}, '{5,6,16}, '{5,0,4096}};
    // clear cases: channel, code, limit, cleared or not
    int cch [8] = '{0,0,0,0,0,0,1,1};
    int ccd [8] = '{1,2,5,6,0,4,1,2};
    int clm [8] = '{5,6,7,8,8,8,5,6};
    // pin cases: channel, code, pin
    int pch [7] = '{0,0,0,0,2,5,4};
    int pcd [7] = '{4,5,6,7,6,7,5};
    int ppn [7] = '{0,1,2,3,2,3,2};

    tcs_timer dut (.CLK_SYS(clk), .RESET_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .EXT_CLOCK_IN_A(ext[0]), .EXT_CLOCK_IN_B(ext[1]),
        .EXT_CLOCK_IN_C(ext[2]), .EXT_CLOCK_IN_D(ext[3]),
        .COUNTER_WRAP(wrap));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // rows take about 50k cycles; the rest is small
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    // one classic cycle; called just after an edge, ends one edge after the ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (ack !== 1'b1) err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input int c, input int g, input logic [31:0] v);
        wb(1'b1, {c[2:0], g[2:0], 2'b00}, v);
    endtask
    task automatic rd(input int c, input int g);
        wb(1'b0, {c[2:0], g[2:0], 2'b00}, 32'h0);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // two counter reads whose take edges lie k cycles apart
    task automatic span(input int c, input int k);
        rd(c, REG_CNT);
        r1 = q;
        repeat (k - 3) @(posedge clk);
        rd(c, REG_CNT);
        q = {16'h0, q[15:0] - r1[15:0]};
    endtask
    // pin pulses stay 3 cycles each way, above the 2-cycle minimum
    task automatic pins(input int i, input int n);
        repeat (n) begin
            ext[i] <= 1'b1;
            repeat (3) @(posedge clk);
            ext[i] <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, cyc, stb, we, adr, wdat, ext} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(0, REG_CTRL);
        chk(q, 32'(CTRL_RESET));
        rd(3, REG_GRA);
        chk(q, 32'(GR_RESET));
        wr(1, REG_CTRL, 32'hff);
        rd(1, REG_CTRL);
        chk(q, 32'h7f);
        wr(0, REG_CTRL, 32'hff);
        rd(0, REG_CTRL);
        chk(q, 32'hff);
        wb(1'b0, 8'he0, 32'h0);
        chk(q, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].ch, REG_CTRL, 32'(rows[i].psc));
            wr(BANK_GLOBAL, REG_START, 32'h1 << rows[i].ch);
            span(rows[i].ch, 4096);
            chk(q, 32'(rows[i].exp));
        end
        // clear sources: A..D compare values 5..8
        for (int k = 0; k < 8; k++) wr(k / 4, REG_GRA + k % 4, 5 + k % 4);
        wr(BANK_GLOBAL, REG_START, 32'h3);
        foreach (ccd[i]) begin
            wr(cch[i], REG_CTRL, 32'(ccd[i] << 5));
            wr(cch[i], REG_CNT, 0);
            repeat (40) @(posedge clk);
            rd(cch[i], REG_CNT);
            chk(32'(q[15:0] <= clm[i]), 32'(ccd[i] % 4 != 0));
        end
        // register C as buffer must not clear the counter
        wr(0, REG_MODE, 32'h1);
        wr(0, REG_CTRL, 32'ha0);
        wr(0, REG_CNT, 0);
        repeat (40) @(posedge clk);
        rd(0, REG_CNT);
        chk(32'(q[15:0] > 8), 32'h1);
        // sync clear follows channel 2 only while channel 1 is enabled
        wr(1, REG_CTRL, 32'h60);
        wr(2, REG_CTRL, 32'h20);
        wr(2, REG_GRA, 32'h3);
        for (int k = 0; k < 2; k++) begin
            wr(BANK_GLOBAL, REG_SYNC, k ? 32'h4 : 32'h6);
            wr(1, REG_CNT, 0);
            wr(2, REG_CNT, 0); // source channel must reach its match soon
            wr(BANK_GLOBAL, REG_START, 32'h6);
            repeat (40) @(posedge clk);
            rd(1, REG_CNT);
            chk(32'(q[15:0] > 8), 32'(k));
        end
        foreach (pcd[i]) begin
            wr(pch[i], REG_CTRL, 32'(pcd[i]));
            wr(BANK_GLOBAL, REG_START, 32'h1 << pch[i]);
            rd(pch[i], REG_CNT);
            r1 = q;
            pins(ppn[i], 3);
            rd(pch[i], REG_CNT);
            chk(32'(q[15:0] - r1[15:0]), 32'h3);
        end
        // neighbour wraps once within 40 cycles from fff0
        for (int k = 1; k < 5; k += 3) begin
            wr(BANK_GLOBAL, REG_START, 0);
            wr(k, REG_CTRL, 32'h7);
            wr(k + 1, REG_CTRL, 32'h0);
            wr(k + 1, REG_CNT, 32'hfff0);
            wr(k, REG_CNT, 0);
            wr(BANK_GLOBAL, REG_START, 32'h3 << k);
            // the source channel's wrap pin pulses exactly once meanwhile
            nw = 0;
            repeat (40) begin
                @(posedge clk);
                nw += int'(wrap[k + 1]);
            end
            rd(k, REG_CNT);
            chk(q, 32'h1);
            chk(32'(nw), 32'h1);
        end
        // phase mode with quiet pins ignores the divide-by-1 code
        wr(1, REG_MODE, 32'h4);
        wr(1, REG_CTRL, 32'h0);
        wr(BANK_GLOBAL, REG_START, 32'h2);
        span(1, 40);
        chk(q, 32'h0);
        // mid-run reset brings back the defaults and drops the wrap pulses
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk(32'(wrap), 32'h0);
        rd(4, REG_CTRL);
        chk(q, 32'(CTRL_RESET));
        rd(2, REG_GRA);
        chk(q, 32'(GR_RESET));
        rd(BANK_GLOBAL, REG_START);
        chk(q, 32'(BITS_RESET));
        tally_and_finish();
    end
endmodule
